// file: include/gpc_regs.svh
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// Register indices; the byte address is four times the index.
`define GPC_IDX_PIN4_CTRL   30'h0000403b
`define GPC_IDX_PIN5_CTRL   30'h0000403c
`define GPC_IDX_OUT_LEVEL   30'h00004040
`define GPC_IDX_PIN_STATUS  30'h00004041

// Control register field positions.
`define GPC_BIT_DIR         15
`define GPC_BIT_PULL_HI     14
`define GPC_BIT_PULL_LO     13
`define GPC_BIT_IRQ_MODE    12
`define GPC_BIT_DOMAIN      11
`define GPC_BIT_POL         10
`define GPC_BIT_OD          9
`define GPC_BIT_ENA         7
`define GPC_FN_HI           3
`define GPC_FN_LO           0

// Reset value and implemented bits of a control register.
`define GPC_CTRL_RESET      16'ha400
`define GPC_CTRL_WMASK      16'hfe8f

// Debounce defaults in nanoseconds, and the period of the 100 MHz clock.
`define GPC_DEB_SHORT_NS    10000
`define GPC_DEB_LONG_NS     20000000
`define GPC_CLK_PERIOD_NS   10

`endif

// file: include/gpc_pkg.sv
package gpc_pkg;

   typedef logic [15:0] gpc_ctrl_t;

   // Pull resistor selection codes.
   typedef enum logic [1:0] {
      GPC_PULL_NONE = 2'h0,
      GPC_PULL_DOWN = 2'h1,
      GPC_PULL_UP   = 2'h2,
      GPC_PULL_RSVD = 2'h3
   } gpc_pull_t;

   // Function codes that matter to the pin logic itself.
   typedef enum logic [3:0] {
      GPC_FN_IN_GP_LONG   = 4'h0,
      GPC_FN_IN_GP        = 4'h1,
      GPC_FN_IN_SLW_LONG  = 4'h4,
      GPC_FN_IN_HWC1_LONG = 4'he,
      GPC_FN_IN_HWC2_LONG = 4'hf
   } gpc_fn_t;

endpackage

// file: hw/gpc_pin_ctrl.sv
// Operation
// RQ1 - Direction resets input; codes 0,1 plain input
// RQ2 - Input codes 2-6 are power/sleep requests
// RQ3 - Input code 7 watchdog; 8,9 scaling selects
// RQ4 - Input codes 10-15 hardware enables and controls
// RQ5 - Output code 0 level; 1 slow oscillator
// RQ6 - Output codes 2-4 state; 5-7 reserved
// RQ7 - Output codes 8-11 scaling done, power enables
// RQ8 - Output codes 12,13 supply and converter good
// RQ9 - Output code 14 power clock; 15 aux reset
// RQ10 - Pull field resets pull-down; 11 reserved
// RQ11 - Edge mode zero: active-going edge interrupts
// RQ12 - Edge mode one: both edges interrupt
// RQ13 - Domain bit selects supply, resets first
// RQ14 - Polarity resets non-inverted; zero inverts
// RQ15 - Output driver push-pull, or open-drain when set
// RQ16 - Enable resets zero, pin tri-stated
// RQ17 - First pin shares driver, enable, function fields
// RQ18 - First pin shares upper fields and defaults
// RQ19 - Undefined bits read zero, ignore writes
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "gpc_regs.svh"

module gpc_pin_ctrl #(
   parameter int DEB_SHORT_CYCLES = `GPC_DEB_SHORT_NS / `GPC_CLK_PERIOD_NS,
   parameter int DEB_LONG_CYCLES  = `GPC_DEB_LONG_NS / `GPC_CLK_PERIOD_NS,
   parameter int NPINS            = 2
) (
   input  wire logic              CLK,
   input  wire logic              RST_N,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [31:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   input  wire logic [3:0]        PSTRB,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic [NPINS-1:0]  PIN_IN,
   output logic      [NPINS-1:0]  PIN_OUT,
   output logic      [NPINS-1:0]  PIN_OE,
   output logic      [NPINS-1:0]  PIN_PULL_UP,
   output logic      [NPINS-1:0]  PIN_PULL_DOWN,
   output logic      [NPINS-1:0]  PIN_SUPPLY_SEL,
   output logic      [NPINS-1:0]  PIN_EDGE_EVENT,
   output logic      [15:0]       ROLE_REQUEST,
   input  wire logic              OSC_32K_CLK,
   input  wire logic              ON_STATE,
   input  wire logic              SLEEP_STATE,
   input  wire logic              POWER_STATE_CHANGE,
   input  wire logic              DVS_DONE_1,
   input  wire logic              DVS_DONE_2,
   input  wire logic              EXT_POWER_ENABLE_1,
   input  wire logic              EXT_POWER_ENABLE_2,
   input  wire logic              SYSTEM_SUPPLY_GOOD_FLAG,
   input  wire logic              CONVERTER_OUTPUT_OK,
   input  wire logic              EXT_POWER_CLK_2M,
   input  wire logic              AUX_RESET
);

   // One spare counter bit keeps the limit compare from ever wrapping.
   localparam int CW = $clog2(DEB_LONG_CYCLES + 1) + 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode helpers.
   ////////////////////////////////////////////////////////////////////////////////

   // Matches a full aligned byte address against a register index.
   // Only a full aligned address hits; PSTRB decides which bytes a write
   // updates, and bits 31:16 of the write data are ignored.
   function automatic logic addr_hit(input logic [31:0] addr, input logic [29:0] idx);
      addr_hit = (addr[31:2] == idx) && (addr[1:0] == 2'h0);
   endfunction

   // Returns which pin control register an address selects, or NPINS for none.
   function automatic int ctrl_sel(input logic [31:0] addr);
      ctrl_sel = NPINS;
      if (addr_hit(addr, `GPC_IDX_PIN4_CTRL)) begin
         ctrl_sel = 0;
      end
      if (addr_hit(addr, `GPC_IDX_PIN5_CTRL)) begin
         ctrl_sel = 1;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave.
   ////////////////////////////////////////////////////////////////////////////////

   gpc_pkg::gpc_ctrl_t          ctrl_q [NPINS];
   logic [NPINS-1:0]            out_level_q;
   logic [NPINS-1:0]            level_q;
   logic [31:0]                 rdata_d;
   logic                        mapped_d;
   logic                        wr_fire;
   logic [15:0]                 wr_lanes;

   // The answer is prepared during setup so the bus outputs come from flops;
   // this gives zero wait states without a combinational read path.
   always_comb begin
      rdata_d  = 32'h0;
      mapped_d = 1'b1;
      if (ctrl_sel(PADDR) < NPINS) begin
         // RQ19 unused bits zero
         rdata_d = {16'h0, ctrl_q[ctrl_sel(PADDR)] & `GPC_CTRL_WMASK};
      end else if (addr_hit(PADDR, `GPC_IDX_OUT_LEVEL)) begin
         rdata_d = {{(32-NPINS){1'b0}}, out_level_q};
      end else if (addr_hit(PADDR, `GPC_IDX_PIN_STATUS)) begin
         rdata_d = {{(32-NPINS){1'b0}}, level_q};
      end else begin
         mapped_d = 1'b0;
      end
   end

   // Write takes effect only at the completing access edge.
   // A refused write leaves every register untouched.
   assign wr_fire  = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
   assign wr_lanes = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};

   // Ready rises for exactly the first access cycle after each setup cycle.
   // Error and read data then stand until the next setup or until PSEL falls.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0;
      end else begin
         PREADY <= PSEL && !PENABLE;
         if (PSEL && !PENABLE) begin
            PSLVERR <= !mapped_d;
            PRDATA  <= PWRITE ? 32'h0 : rdata_d;
         end else if (!PSEL) begin
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0;
         end
      end
   end

   // Software output level for pins in general-purpose output mode.
   // Only lane 0 carries the level bits; the other lanes are ignored.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         out_level_q <= '0;
      end else if (wr_fire && addr_hit(PADDR, `GPC_IDX_OUT_LEVEL) && PSTRB[0]) begin
         out_level_q <= PWDATA[NPINS-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers for the status sources selectable as pin outputs.
   ////////////////////////////////////////////////////////////////////////////////

   logic [15:0] src_raw;
   logic [15:0] src_meta_q;
   logic [15:0] src_q;

   // Index is the output function code; unused codes carry a constant low.
   // A pin set to a reserved code therefore drives its inactive level,
   // which is the safe choice for a code that must not be relied upon.
   assign src_raw = {AUX_RESET, EXT_POWER_CLK_2M, CONVERTER_OUTPUT_OK,
                     SYSTEM_SUPPLY_GOOD_FLAG, EXT_POWER_ENABLE_2, EXT_POWER_ENABLE_1,
                     DVS_DONE_2, DVS_DONE_1, 3'h0, POWER_STATE_CHANGE,
                     SLEEP_STATE, ON_STATE, OSC_32K_CLK, 1'b0};

   // Two stages because every source is asynchronous to CLK. The 2 MHz clock
   // survives this at 100 MHz, though with up to 10 ns of jitter.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         src_meta_q <= 16'h0;
         src_q      <= 16'h0;
      end else begin
         src_meta_q <= src_raw;
         src_q      <= src_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-pin logic.
   ////////////////////////////////////////////////////////////////////////////////

   // Each pin runs the same chain: pad synchroniser, debounce, edge detect,
   // role decode and output mux. Changing the function code mid-count keeps
   // the count but applies the new limit, so a long-debounce pin switched to
   // a short code may accept a change early; software should switch codes
   // while the pin is disabled.
   logic [NPINS-1:0] role_vld [16];

   genvar p;
   generate
      for (p = 0; p < NPINS; p++) begin : g_pin
         logic              in_meta_q;
         logic              in_sync_q;
         logic [CW-1:0]     deb_cnt_q;
         logic [CW-1:0]     deb_lim;
         logic              active_lvl;
         logic              level_prev_q;
         logic              rise_evt;
         logic              fall_evt;
         logic              is_input;
         logic              is_long;
         logic              drive_val;
         logic [3:0]        fn;
         gpc_pkg::gpc_pull_t pull;

         // Field views of this pin's control word.
         assign fn   = ctrl_q[p][`GPC_FN_HI:`GPC_FN_LO];
         assign pull = gpc_pkg::gpc_pull_t'(ctrl_q[p][`GPC_BIT_PULL_HI:`GPC_BIT_PULL_LO]);

         // RQ17 shared control fields
         // RQ18 same defaults both pins
         // RQ1 direction resets input
         // RQ19 reserved writes dropped
         always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
               ctrl_q[p] <= `GPC_CTRL_RESET;
            end else if (wr_fire && ctrl_sel(PADDR) == p) begin
               ctrl_q[p] <= (ctrl_q[p] & ~(wr_lanes & `GPC_CTRL_WMASK)) |
                            (PWDATA[15:0] & wr_lanes & `GPC_CTRL_WMASK);
            end
         end

         // The pad is asynchronous, so it passes two flops first.
         always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
               in_meta_q <= 1'b0;
               in_sync_q <= 1'b0;
            end else begin
               in_meta_q <= PIN_IN[p];
               in_sync_q <= in_meta_q;
            end
         end

         // Direction bit set means the pin is an input.
         assign is_input = ctrl_q[p][`GPC_BIT_DIR];

         // RQ1 long debounce codes
         assign is_long = (fn == gpc_pkg::GPC_FN_IN_GP_LONG) ||
                          (fn == gpc_pkg::GPC_FN_IN_SLW_LONG) ||
                          (fn == gpc_pkg::GPC_FN_IN_HWC1_LONG) ||
                          (fn == gpc_pkg::GPC_FN_IN_HWC2_LONG);
         assign deb_lim = is_long ? CW'(DEB_LONG_CYCLES) : CW'(DEB_SHORT_CYCLES);

         // A change is accepted only after it has held for the whole debounce
         // time; any bounce back restarts the count.
         // The next count is compared, so exactly deb_lim stable cycles are needed.
         always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
               deb_cnt_q  <= '0;
               level_q[p] <= 1'b0;
            end else if (in_sync_q == level_q[p]) begin
               deb_cnt_q <= '0;
            end else if (deb_cnt_q + CW'(1) >= deb_lim) begin
               deb_cnt_q  <= '0;
               level_q[p] <= in_sync_q;
            end else begin
               deb_cnt_q <= deb_cnt_q + CW'(1);
            end
         end

         // RQ14 polarity inverts level
         assign active_lvl = level_q[p] ^ !ctrl_q[p][`GPC_BIT_POL];

         // The edge detector follows the debounced level itself, not the
         // polarity-applied one, so rewriting the polarity bit never fakes an
         // interrupt on a pin whose level stood still.
         always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
               level_prev_q <= 1'b0;
            end else begin
               level_prev_q <= level_q[p];
            end
         end

         // Raw edges of the debounced level.
         assign rise_evt = level_q[p] && !level_prev_q;
         assign fall_evt = !level_q[p] && level_prev_q;

         // Edge events only count while the pin is an enabled input.
         always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
               PIN_EDGE_EVENT[p] <= 1'b0;
            end else if (ctrl_q[p][`GPC_BIT_ENA] && is_input) begin
               if (ctrl_q[p][`GPC_BIT_IRQ_MODE]) begin
                  // RQ12 both edges fire
                  PIN_EDGE_EVENT[p] <= rise_evt || fall_evt;
               end else begin
                  // RQ11 polarity picks edge
                  PIN_EDGE_EVENT[p] <= ctrl_q[p][`GPC_BIT_POL] ? rise_evt : fall_evt;
               end
            end else begin
               PIN_EDGE_EVENT[p] <= 1'b0;
            end
         end

         // Roles need the pin enabled and set as input, as events do.
         // RQ2 request roles decoded
         // RQ3 watchdog and scaling roles
         // RQ4 hardware enable roles
         for (genvar c = 0; c < 16; c++) begin : g_role
            assign role_vld[c][p] = ctrl_q[p][`GPC_BIT_ENA] && is_input &&
                                    (fn == 4'(c)) && active_lvl;
         end

         // RQ5 level or oscillator
         // RQ6 reserved codes drive inactive
         // RQ7 scaling and enables
         // RQ8 supply good sources
         // RQ9 clock and aux reset
         always_comb begin
            if (fn == 4'h0) begin
               drive_val = out_level_q[p];
            end else begin
               drive_val = src_q[fn];
            end
         end

         // A released open-drain pin is left to its pull or to the far side.
         // RQ16 disabled pin floats
         // RQ15 open drain drives low only
         always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
               PIN_OUT[p] <= 1'b0;
               PIN_OE[p]  <= 1'b0;
            end else begin
               PIN_OUT[p] <= ctrl_q[p][`GPC_BIT_OD] ? 1'b0
                             : (drive_val ^ !ctrl_q[p][`GPC_BIT_POL]);
               PIN_OE[p]  <= ctrl_q[p][`GPC_BIT_ENA] && !is_input &&
                             (!ctrl_q[p][`GPC_BIT_OD] ||
                              !(drive_val ^ !ctrl_q[p][`GPC_BIT_POL]));
            end
         end

         // Pull and supply follow the field even while the pin is disabled,
         // so a tri-stated pad still rests at a defined level.
         // RQ10 pull selection
         // RQ13 supply domain select
         always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
               PIN_PULL_UP[p]    <= 1'b0;
               PIN_PULL_DOWN[p]  <= 1'b1;
               PIN_SUPPLY_SEL[p] <= 1'b0;
            end else begin
               PIN_PULL_UP[p]    <= pull == gpc_pkg::GPC_PULL_UP;
               PIN_PULL_DOWN[p]  <= pull == gpc_pkg::GPC_PULL_DOWN;
               PIN_SUPPLY_SEL[p] <= ctrl_q[p][`GPC_BIT_DOMAIN];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Role outputs toward system logic.
   ////////////////////////////////////////////////////////////////////////////////

   // Either pin may carry a role; both pins in one role are simply ORed.
   // The role bus is registered so that every output comes from a flop.
   genvar r;
   generate
      for (r = 0; r < 16; r++) begin : g_role_out
         always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
               ROLE_REQUEST[r] <= 1'b0;
            end else begin
               ROLE_REQUEST[r] <= |role_vld[r];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// file: verification/gpc_checker.sv
`timescale 1ns/10ps
`default_nettype none

module gpc_checker #(
   parameter int NPINS = 2
) (
   input wire logic             CLK,
   input wire logic             RST_N,
   input wire logic             PSEL,
   input wire logic             PENABLE,
   input wire logic             PWRITE,
   input wire logic [31:0]      PRDATA,
   input wire logic             PREADY,
   input wire logic             PSLVERR,
   input wire logic [NPINS-1:0] PIN_OE,
   input wire logic [NPINS-1:0] PIN_PULL_UP,
   input wire logic [NPINS-1:0] PIN_PULL_DOWN,
   input wire logic [NPINS-1:0] PIN_EDGE_EVENT
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   ////////////////////////
   // Bus steps: a setup cycle, then one ready cycle.
   sequence setup_s; PSEL && !PENABLE; endsequence
   sequence answer_s; PREADY ##1 !PREADY; endsequence
   answer_next_a:
      assert property (setup_s |=> answer_s) else $error("ready missing after setup.");
   ready_cause_a:
      assert property ($rose(PREADY) |-> $past(PSEL) && !$past(PENABLE))
      else $error("ready without setup.");
   err_data_a:
      assert property (PREADY && PSLVERR |-> PRDATA == 32'h0) else $error("error read not zero.");
   rsvd_zero_a:
      assert property (PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0 && !PRDATA[8]
         && PRDATA[6:4] == 3'h0) else $error("reserved bits not zero.");
   write_zero_a:
      assert property (PREADY && PWRITE |-> PRDATA == 32'h0) else $error("write data not zero.");
   pull_excl_a:
      assert property ((PIN_PULL_UP & PIN_PULL_DOWN) == '0) else $error("both pulls on.");
   edge_single_a:
      assert property (PIN_EDGE_EVENT[0] |=> !PIN_EDGE_EVENT[0] [*3]) else $error("long pulse.");
   oe_quiet_a:
      assert property ((PIN_OE & PIN_EDGE_EVENT) == '0) else $error("event on output.");
endmodule

bind gpc_pin_ctrl gpc_checker #(.NPINS(NPINS)) chk_u (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .PIN_OE(PIN_OE), .PIN_PULL_UP(PIN_PULL_UP), .PIN_PULL_DOWN(PIN_PULL_DOWN),
   .PIN_EDGE_EVENT(PIN_EDGE_EVENT));
`default_nettype wire

// file: verification/gpc_pad_model.sv
`timescale 1ns/10ps
`default_nettype none

module gpc_pad_model (
   input wire logic        clk,
   input wire logic [1:0]  drv_oe,
   input wire logic [1:0]  drv_val,
   input wire logic [1:0]  pull_up,
   input wire logic [1:0]  pull_dn,
   input wire logic [1:0]  host_en,
   input wire logic [1:0]  host_val,
   output logic     [1:0]  pad
);
   logic [1:0] flip_q = 2'h1;
   // A floating pad toggles so a stale level never looks valid.
   always_ff @(posedge clk) begin
      flip_q <= ~flip_q;
   end
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pad[i] = drv_oe[i] ? drv_val[i] : host_en[i] ? host_val[i] :
                  pull_up[i] ? 1'b1 : pull_dn[i] ? 1'b0 : flip_q[i];
      end
   end
endmodule
`default_nettype wire

// file: verification/gpio_pin_control_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpc_regs.svh"

module gpio_pin_control_regs_test;
   localparam logic [31:0] A4 = {`GPC_IDX_PIN4_CTRL, 2'h0};
   localparam logic [31:0] A5 = {`GPC_IDX_PIN5_CTRL, 2'h0};
   localparam logic [31:0] AO = {`GPC_IDX_OUT_LEVEL, 2'h0};
   localparam logic [31:0] AS = {`GPC_IDX_PIN_STATUS, 2'h0};
   logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [31:0] PADDR = 0, PWDATA = 0, PRDATA;
   logic [15:0] src = 0, ROLE;
   logic [1:0] hen = 2'h3, hval = 0, PIN_IN, OUT, OE, PU, PD, SEL, EV;
   logic PREADY, PSLVERR, e;
   logic [3:0] strb = 4'hf;
   logic [31:0] rv;
   int fail_count = 0, checks_done = 0;
   // Free-running 100 MHz clock.
   always #5 CLK = ~CLK;
   gpc_pin_ctrl #(.DEB_SHORT_CYCLES(4), .DEB_LONG_CYCLES(16), .NPINS(2)) dut_u (.CLK(CLK),
      .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PSTRB(strb), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .PIN_IN(PIN_IN), .PIN_OUT(OUT), .PIN_OE(OE), .PIN_PULL_UP(PU), .PIN_PULL_DOWN(PD),
      .PIN_SUPPLY_SEL(SEL), .PIN_EDGE_EVENT(EV), .ROLE_REQUEST(ROLE), .OSC_32K_CLK(src[1]),
      .ON_STATE(src[2]), .SLEEP_STATE(src[3]), .POWER_STATE_CHANGE(src[4]),
      .DVS_DONE_1(src[8]), .DVS_DONE_2(src[9]), .EXT_POWER_ENABLE_1(src[10]),
      .EXT_POWER_ENABLE_2(src[11]), .SYSTEM_SUPPLY_GOOD_FLAG(src[12]),
      .CONVERTER_OUTPUT_OK(src[13]), .EXT_POWER_CLK_2M(src[14]), .AUX_RESET(src[15]));
   gpc_pad_model pad_u (.clk(CLK), .drv_oe(OE), .drv_val(OUT), .pull_up(PU), .pull_dn(PD),
      .host_en(hen), .host_val(hval), .pad(PIN_IN));
   ////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request is held until ready is seen; data is taken at that edge.
   task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      int n;
      @(posedge CLK);
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
      @(posedge CLK);
      PENABLE <= 1;
      for (n = 0; n < 20; n++) begin
         @(posedge CLK);
         if (PREADY === 1'b1) break;
      end
      r = PRDATA;
      e = PSLVERR;
      {PSEL, PENABLE} <= 2'b00;
      if (n == 20) begin
         fail_count++;
         test_done();
      end
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      apb(1, a, d, r);
      // Let the new setting reach the registered pin outputs.
      repeat (2) @(posedge CLK);
   endtask
   task automatic rd(input logic [31:0] a, exp, input logic eexp);
      logic [31:0] r;
      apb(0, a, 0, r);
      chk(r, exp);
      chk(e, eexp);
   endtask
   // Drives the first pad and counts event pulses over a window.
   task automatic edges(input logic v, input int win, input int exp);
      int n;
      n = 0;
      hval[0] <= v;
      repeat (win) begin
         @(negedge CLK);
         n += (EV[0] === 1'b1);
      end
      chk(n, exp);
      @(posedge CLK);
   endtask
   ////////////////////////
   // Main sequence: reset, registers, output roles, input roles.
   initial begin
      repeat (12) @(posedge CLK);
      RST_N <= 1;
      chk(PD, 32'h3);
      rd(A4, 32'ha400, 0);
      rd(A5, 32'ha400, 0);
      wr(A4, 32'hffffffff);
      rd(A4, 32'hfe8f, 0);
      strb <= 4'h1;
      wr(A4, 32'h0);
      strb <= 4'hf;
      rd(A4, 32'hfe00, 0);
      rd(32'h10200, 0, 1);
      wr(A5, 32'hc800);
      chk({PU, PD, SEL}, 32'h23);
      hen <= 2'h1;
      for (int k = 0; k < 16; k++) begin
         wr(A5, 32'h0480 | k);
         for (int v = 0; v < 2; v++) begin
            src <= v ? 16'h1 << k : ~(16'h1 << k);
            wr(AO, v << 1);
            repeat (4) @(posedge CLK);
            chk({OE[1], OUT[1]}, {1'b1, (k < 5 || k > 7) && v});
         end
      end
      rd(AO, 32'h2, 0);
      wr(A5, 32'h0080);
      chk({OE[1], OUT[1]}, 32'h2);
      wr(A5, 32'h0680);
      chk({OE[1], OUT[1]}, 32'h0);
      wr(AO, 0);
      chk({OE[1], OUT[1]}, 32'h2);
      wr(A5, 32'h0400);
      chk(OE[1], 0);
      wr(A4, 32'h8481);
      edges(1, 14, 1);
      chk(ROLE[1], 1);
      apb(0, AS, 0, rv);
      chk({e, rv[31:2], rv[0]}, 32'h1);
      edges(0, 30, 0);
      wr(A4, 32'h9481);
      edges(1, 30, 1);
      edges(0, 30, 1);
      wr(A4, 32'h8081);
      edges(1, 30, 0);
      edges(0, 30, 1);
      wr(A4, 32'h8480);
      edges(1, 14, 0);
      edges(1, 30, 1);
      for (int k = 0; k < 16; k++) begin
         wr(A4, 32'h8480 | k);
         repeat (30) @(posedge CLK);
         chk(ROLE, 16'h1 << k);
      end
      wr(A4, 32'h8001);
      edges(0, 40, 0);
      test_done();
   end
endmodule
`default_nettype wire
